// ==== src/sfm_defs.svh ====
// Constants of the sample buffer: offsets, fields, reset values and counts
`ifndef SFM_DEFS_SVH
`define SFM_DEFS_SVH

// ----------------------------------------------------------------------
// Configuration register offsets and fields
// ----------------------------------------------------------------------
`define SFM_ADDR_CTRL 8'h28
`define SFM_ADDR_SAMPLES 8'h29
`define SFM_CTRL_MODE_LSB 0
`define SFM_CTRL_MODE_MSB 1
`define SFM_CTRL_TEMP_BIT 2
`define SFM_CTRL_THRESHOLD_HIGH_BIT 3
`define SFM_CTRL_RST 8'h00
`define SFM_SAMPLES_RST 8'h80

// ----------------------------------------------------------------------
// Buffer geometry
// ----------------------------------------------------------------------
`define SFM_DEPTH_LOG2 9
`define SFM_SETS_NO_TEMP 170
`define SFM_SETS_TEMP 128

// ----------------------------------------------------------------------
// Entry layout
// ----------------------------------------------------------------------
`define SFM_TAG_X 2'b00
`define SFM_TAG_Y 2'b01
`define SFM_TAG_Z 2'b10
`define SFM_TAG_T 2'b11
`define SFM_EMPTY_BYTE 8'h00

`endif

// ==== src/sfm_entry_fmt.sv ====
// Builds one tagged, sign-extended buffer entry
`timescale 1ns/1ps
module sfm_entry_fmt (
  // Datum
  input wire logic [1:0] tag,
  input wire sfm_pkg::sfm_value_type value,
  // Entry
  output sfm_pkg::sfm_entry_type entry
);

  always_comb begin
    entry = {tag, {2{value[11]}}, value}; // RULE13 RULE14 RULE15
  end

endmodule

// ==== src/sfm_pkg.sv ====
// Types shared by the sample buffer modules
package sfm_pkg;

  typedef enum logic [1:0] {
    SFM_OFF = 2'b00,
    SFM_OLDEST = 2'b01,
    SFM_STREAM = 2'b10,
    SFM_TRIG = 2'b11
  } sfm_mode_type;

  typedef enum logic [2:0] {
    SFM_W_IDLE = 3'b000,
    SFM_W_X = 3'b001,
    SFM_W_Y = 3'b010,
    SFM_W_Z = 3'b011,
    SFM_W_T = 3'b100
  } sfm_wstate_type;

  typedef logic [15:0] sfm_entry_type;
  typedef logic [11:0] sfm_value_type;

endpackage

// ==== src/sfm_sync.sv ====
// Two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module sfm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  if (WIDTH < 1) begin : g_bad_width
    $error("sfm_sync: width must be at least one");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sfm_sync_state_type;

  sfm_sync_state_type s_q;
  sfm_sync_state_type s_d;

  always_comb begin
    s_d.meta = d;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stable;

endmodule

// ==== src/sfm_top.sv ====
// Sample buffer with four modes, fill flags and byte-wise read-out
`timescale 1ns/1ps
`include "sfm_defs.svh"

// How it works
// RULE1 - Buffer holds 512 entries, one axis or temperature datum each.
// RULE2 - Room for 170 three-axis sets, or 128 sets with temperature.
// RULE3 - Mode 00 stores nothing and empties the buffer.
// RULE4 - Mode 01 fills, then drops new samples until reads free space.
// RULE5 - Mode 10 keeps newest data, dropping oldest entry when full.
// RULE6 - In stream mode, reaching the threshold raises the level flag.
// RULE7 - Mode 11 captures once around an activity event.
// RULE8 - Triggered mode keeps threshold-count entries from before the event.
// RULE9 - Mode, count and options come from the two configuration bytes.
// RULE10 - Flags: data available, threshold reached, samples lost.
// RULE11 - Host reads entries with the buffer read command, 16 bits each.
// RULE12 - Low byte of each entry goes out first, high byte second.
// RULE13 - Bits 11 to 0 hold the twos complement value.
// RULE14 - Bits 13 and 12 repeat the value's sign.
// RULE15 - Bits 15 and 14 tag X, Y, Z or temperature.
// RULE16 - Each set is written X, Y, Z, then temperature if selected.
// RULE17 - Bytes read from an empty buffer return zero.
// RULE18 - Level flag holds while count is at or above threshold.
// RULE19 - Overflow sets on lost data, clears on read or disable.
// RULE20 - After the event, fill remaining room, then stop until re-armed.
// RULE21 - Each entry read frees one entry, even splitting a set.
module sfm_top #(
  parameter int PTR_W = `SFM_DEPTH_LOG2
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Configuration bytes
  input wire logic [7:0] cfg_ctrl,
  input wire logic [7:0] cfg_samples,
  // Measurement path
  input wire logic sample_valid,
  input wire sfm_pkg::sfm_value_type sample_x,
  input wire sfm_pkg::sfm_value_type sample_y,
  input wire sfm_pkg::sfm_value_type sample_z,
  input wire sfm_pkg::sfm_value_type sample_t,
  input wire logic activity_event,
  // Read command framing
  input wire logic read_start,
  // Status
  output logic data_ready,
  output logic level_reached,
  output logic overflow,
  output logic [PTR_W:0] entry_count,
  // Link side
  input wire logic link_clk,
  input wire logic link_byte_req,
  output logic [7:0] link_byte,
  output logic link_byte_valid,
  output logic link_busy
);

  localparam int DEPTH = 1 << PTR_W;
  localparam logic [PTR_W:0] FULL_CNT = {1'b1, {PTR_W{1'b0}}};

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (PTR_W != `SFM_DEPTH_LOG2 || 3 * `SFM_SETS_NO_TEMP > DEPTH ||
      4 * `SFM_SETS_TEMP > DEPTH) begin : g_bad_depth
    $error("sfm_top: depth must be 512 entries");
  end

  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
    sfm_pkg::sfm_wstate_type wstate;
    logic [3:0][11:0] set;
    logic trig;
    logic done;
    logic ovf;
    logic ready;
    logic level;
    logic phase;
    logic [7:0] hi_byte;
    logic [7:0] rd_byte;
    logic ack_tgl;
    logic req_seen;
  } sfm_sys_state_type;

  typedef struct packed {
    logic req_tgl;
    logic ack_seen;
    logic busy;
    logic [7:0] rd_byte;
    logic valid;
  } sfm_link_state_type;

  sfm_sys_state_type s_q;
  sfm_sys_state_type s_d;
  sfm_link_state_type l_q;
  sfm_link_state_type l_d;

  // ----------------------------------------------------------------------
  // Decoded configuration and events
  // ----------------------------------------------------------------------
  sfm_pkg::sfm_mode_type mode;
  logic [PTR_W:0] thr;
  logic req_sync;
  logic ack_sync;
  logic rq_edge;
  logic ack_edge;
  logic wr_req;
  logic full;
  logic pop;
  logic [1:0] wr_tag;
  sfm_pkg::sfm_value_type wr_val;
  sfm_pkg::sfm_entry_type wr_entry;
  sfm_pkg::sfm_entry_type head;

  assign mode = sfm_pkg::sfm_mode_type'(cfg_ctrl[`SFM_CTRL_MODE_MSB:`SFM_CTRL_MODE_LSB]); // RULE9
  assign thr = {1'b0, cfg_ctrl[`SFM_CTRL_THRESHOLD_HIGH_BIT], cfg_samples}; // RULE9
  assign rq_edge = req_sync ^ s_q.req_seen;
  assign ack_edge = ack_sync ^ l_q.ack_seen;
  assign wr_req = s_q.wstate != sfm_pkg::SFM_W_IDLE;
  assign full = s_q.count == FULL_CNT;
  assign head = s_q.mem[s_q.rd_ptr];
  assign pop = rq_edge && !s_q.phase && s_q.count != '0; // RULE21

  always_comb begin
    unique case (s_q.wstate)
      sfm_pkg::SFM_W_X: wr_tag = `SFM_TAG_X;
      sfm_pkg::SFM_W_Y: wr_tag = `SFM_TAG_Y;
      sfm_pkg::SFM_W_Z: wr_tag = `SFM_TAG_Z;
      default: wr_tag = `SFM_TAG_T;
    endcase
  end

  assign wr_val = s_q.set[wr_tag];
  sfm_entry_fmt u_fmt (
    .tag(wr_tag),
    .value(wr_val),
    .entry(wr_entry)
  );
  sfm_sync #(.WIDTH(1)) u_req_sync (
    .clk(clk_sys),
    .reset_n(reset_n),
    .d(l_q.req_tgl),
    .q(req_sync)
  );
  sfm_sync #(.WIDTH(1)) u_ack_sync (
    .clk(link_clk),
    .reset_n(reset_n),
    .d(s_q.ack_tgl),
    .q(ack_sync)
  );

  // ----------------------------------------------------------------------
  // System domain: storage, modes, flags and read-out
  // ----------------------------------------------------------------------
  always_comb begin
    logic store;
    logic drop_old;
    logic lost;
    store = 1'b0;
    drop_old = 1'b0;
    lost = 1'b0;
    s_d = s_q;

    // Entry sequencing per set
    unique case (s_q.wstate)
      sfm_pkg::SFM_W_IDLE: begin
        if (sample_valid && mode != sfm_pkg::SFM_OFF) begin
          s_d.set = {sample_t, sample_z, sample_y, sample_x};
          s_d.wstate = sfm_pkg::SFM_W_X; // RULE16
        end
      end
      sfm_pkg::SFM_W_X: s_d.wstate = sfm_pkg::SFM_W_Y; // RULE16
      sfm_pkg::SFM_W_Y: s_d.wstate = sfm_pkg::SFM_W_Z; // RULE16
      sfm_pkg::SFM_W_Z: begin
        s_d.wstate = cfg_ctrl[`SFM_CTRL_TEMP_BIT] ? sfm_pkg::SFM_W_T // RULE2
                                                  : sfm_pkg::SFM_W_IDLE;
      end
      sfm_pkg::SFM_W_T: s_d.wstate = sfm_pkg::SFM_W_IDLE;
      default: s_d.wstate = sfm_pkg::SFM_W_IDLE;
    endcase

    // Store decision per mode
    if (wr_req) begin
      unique case (mode)
        sfm_pkg::SFM_OLDEST: begin
          if (!full || pop) begin
            store = 1'b1; // RULE4
          end else begin
            lost = 1'b1; // RULE4 RULE19
          end
        end
        sfm_pkg::SFM_STREAM: begin
          store = 1'b1; // RULE5
          if (full && !pop) begin
            drop_old = 1'b1; // RULE5
            lost = 1'b1; // RULE19
          end
        end
        sfm_pkg::SFM_TRIG: begin
          if (!s_q.trig) begin
            store = 1'b1; // RULE7
            if (s_q.count >= thr && !pop) begin
              drop_old = 1'b1; // RULE8
            end
          end else if (!s_q.done && (!full || pop)) begin
            store = 1'b1; // RULE20
          end
        end
        default: store = 1'b0; // RULE3
      endcase
    end

    if (store) begin
      s_d.mem[s_q.wr_ptr] = wr_entry; // RULE1
      s_d.wr_ptr = s_q.wr_ptr + 1'b1;
    end
    if (pop || drop_old) begin
      s_d.rd_ptr = s_q.rd_ptr + 1'b1; // RULE21
    end
    if (store && !(pop || drop_old)) begin
      s_d.count = s_q.count + 1'b1;
    end else if (!store && (pop || drop_old)) begin
      s_d.count = s_q.count - 1'b1; // RULE21
    end

    // One-shot capture control
    if (mode != sfm_pkg::SFM_TRIG) begin
      s_d.trig = 1'b0;
      s_d.done = 1'b0;
    end else begin
      if (activity_event) begin
        s_d.trig = 1'b1; // RULE7
      end
      if (s_q.trig && s_d.count == FULL_CNT) begin
        s_d.done = 1'b1; // RULE20
      end
    end

    // Lost data wins over a clearing read
    s_d.ovf = lost || (s_q.ovf && !pop); // RULE19

    if (mode == sfm_pkg::SFM_OFF) begin
      s_d.wr_ptr = '0; // RULE3
      s_d.rd_ptr = '0;
      s_d.count = '0; // RULE3
      s_d.ovf = 1'b0; // RULE19
      s_d.wstate = sfm_pkg::SFM_W_IDLE;
    end

    s_d.ready = s_d.count != '0; // RULE10
    s_d.level = s_d.count >= thr; // RULE6 RULE10 RULE18

    // Byte read-out, low byte first
    if (read_start) begin
      s_d.phase = 1'b0;
    end
    if (rq_edge) begin
      s_d.req_seen = req_sync;
      s_d.ack_tgl = ~s_q.ack_tgl;
      if (!s_q.phase) begin
        s_d.phase = 1'b1;
        if (s_q.count != '0) begin
          s_d.rd_byte = head[7:0]; // RULE11 RULE12
          s_d.hi_byte = head[15:8];
        end else begin
          s_d.rd_byte = `SFM_EMPTY_BYTE; // RULE17
          s_d.hi_byte = `SFM_EMPTY_BYTE; // RULE17
        end
      end else begin
        s_d.phase = 1'b0;
        s_d.rd_byte = s_q.hi_byte; // RULE12
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: byte request handshake
  // ----------------------------------------------------------------------
  always_comb begin
    l_d = l_q;
    l_d.valid = 1'b0;
    if (link_byte_req && !l_q.busy) begin
      l_d.req_tgl = ~l_q.req_tgl;
      l_d.busy = 1'b1;
    end
    if (ack_edge) begin
      l_d.ack_seen = ack_sync;
      l_d.busy = 1'b0;
      l_d.rd_byte = s_q.rd_byte; // RULE11
      l_d.valid = 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign data_ready = s_q.ready;
  assign level_reached = s_q.level;
  assign overflow = s_q.ovf;
  assign entry_count = s_q.count;
  assign link_byte = l_q.rd_byte;
  assign link_byte_valid = l_q.valid;
  assign link_busy = l_q.busy;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_wr_x;
    s_q.wstate == sfm_pkg::SFM_W_X;
  endsequence
  sequence s_wr_yz;
    s_q.wstate == sfm_pkg::SFM_W_Y ##1 s_q.wstate == sfm_pkg::SFM_W_Z;
  endsequence
  a_set_order: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE16
      s_wr_x |=> s_wr_yz)
    else $error("entries of a set not written in X, Y, Z order");
  a_count_bound: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE1
      s_q.count <= FULL_CNT)
    else $error("stored count above capacity");
  a_off_clears: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE3
      mode == sfm_pkg::SFM_OFF |=> s_q.count == '0 && !s_q.ovf)
    else $error("disabled buffer still holds entries or overflow");
  a_oldest_drop: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE4
      mode == sfm_pkg::SFM_OLDEST && wr_req && full && !pop
      |=> s_q.ovf && s_q.count == FULL_CNT && s_q.wr_ptr == $past(s_q.wr_ptr))
    else $error("oldest-saved mode stored into a full buffer");
  a_stream_keep: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE5
      mode == sfm_pkg::SFM_STREAM && wr_req && full && !pop
      |=> s_q.ovf && s_q.count == FULL_CNT && s_q.rd_ptr == $past(s_q.rd_ptr) + 1'b1)
    else $error("stream mode did not replace oldest entry");
  a_level_track: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE18
      1'b1 |=> s_q.level == (s_q.count >= $past(thr)))
    else $error("level flag disagrees with count and threshold");
  a_ready_track: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE10
      s_q.ready == (s_q.count != '0))
    else $error("data-ready flag disagrees with count");
  a_empty_zero: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE17
      rq_edge && !s_q.phase && s_q.count == '0
      |=> s_q.rd_byte == `SFM_EMPTY_BYTE ##1 !rq_edge || s_q.hi_byte == `SFM_EMPTY_BYTE)
    else $error("empty buffer read returned non-zero byte");
  a_low_first: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE12
      pop && mode != sfm_pkg::SFM_OFF && !s_q.done |=> s_q.rd_byte == $past(head[7:0]) &&
      s_q.hi_byte == $past(head[15:8]) && s_q.count == $past(s_q.count) - 1'b1 + $past(wr_req))
    else $error("read did not return low byte first");
  a_valid_pulse: assert property (@(posedge link_clk) disable iff (!reset_n) // RULE11
      l_q.valid |=> !l_q.valid)
    else $error("link byte valid held longer than one cycle");

endmodule

// ==== test/sfm_host_model.sv ====
// Host side model: pulls buffer bytes over the link channel
`timescale 1ns/1ps
module sfm_host_model (
  // Link clock
  input wire logic link_clk,
  // Byte channel
  output logic link_byte_req,
  input wire logic [7:0] link_byte,
  input wire logic link_byte_valid,
  input wire logic link_busy
);
  initial link_byte_req = 1'b0;

  // One byte; starts on a link falling edge, stall adds idle cycles
  task automatic read_byte(input int stall, output logic [7:0] b);
    int n;
    n = 0;
    repeat (stall + 1) @(negedge link_clk);
    while (link_busy !== 1'b0 && n < 64) begin
      @(negedge link_clk);
      n++;
    end
    link_byte_req = 1'b1;
    @(negedge link_clk);
    link_byte_req = 1'b0;
    while (link_byte_valid !== 1'b1 && n < 128) begin
      @(negedge link_clk);
      n++;
    end
    b = link_byte;
  endtask

  // One entry: low byte, then high byte
  task automatic read_word(input int stall, output logic [15:0] w);
    logic [7:0] lo;
    logic [7:0] hi;
    read_byte(stall, lo);
    read_byte(stall, hi);
    w = {hi, lo};
  endtask
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench of the sample buffer
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
    logic [11:0] t;
  } sfm_row_type;
  logic clk_sys, reset_n, link_clk, sample_valid, activity_event, read_start;
  logic [7:0] cfg_ctrl, cfg_samples, link_byte;
  sfm_pkg::sfm_value_type sx, sy, sz, st;
  logic data_ready, level_reached, overflow, link_byte_req, link_byte_valid, link_busy;
  logic [9:0] entry_count;
  logic [15:0] e;
  logic [11:0] v [4];
  int failures, checks_done, n;
  sfm_row_type rows [4];

  sfm_top sfm_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .cfg_ctrl(cfg_ctrl),
    .cfg_samples(cfg_samples), .sample_valid(sample_valid), .sample_x(sx), .sample_y(sy),
    .sample_z(sz), .sample_t(st), .activity_event(activity_event),
    .read_start(read_start), .data_ready(data_ready), .level_reached(level_reached),
    .overflow(overflow), .entry_count(entry_count), .link_clk(link_clk),
    .link_byte_req(link_byte_req), .link_byte(link_byte),
    .link_byte_valid(link_byte_valid), .link_busy(link_busy));
  sfm_host_model sfm_host_model_i (.link_clk(link_clk), .link_byte_req(link_byte_req),
    .link_byte(link_byte), .link_byte_valid(link_byte_valid), .link_busy(link_busy));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] ent(input logic [1:0] g, input logic [11:0] d);
    ent = {g, d[11], d[11], d};
  endfunction
  task automatic cfg(input logic [7:0] c, input logic [7:0] s);
    @(negedge clk_sys);
    cfg_ctrl = c;
    cfg_samples = s;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic put4(input logic [11:0] a, b, c, d);
    @(negedge clk_sys);
    sample_valid = 1'b1;
    sx = a;
    sy = b;
    sz = c;
    st = d;
    @(negedge clk_sys);
    sample_valid = 1'b0;
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic fill(input int a, input int cnt);
    for (int j = a; j < a + cnt; j++) put4(12'(j), 12'(j), 12'(j), 12'(j));
  endtask
  task automatic rd(input int stall, output logic [15:0] w);
    @(negedge clk_sys);
    read_start = 1'b1;
    @(negedge clk_sys);
    read_start = 1'b0;
    sfm_host_model_i.read_word(stall, w);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    failures++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    {reset_n, sample_valid, activity_event, read_start, sx, sy, sz, st} = '0;
    cfg_ctrl = 8'h00;
    cfg_samples = 8'h80;
    rows[0] = '{8'h02, 12'h001, 12'h800, 12'hfff, 12'h000};
    rows[1] = '{8'h06, 12'h7ff, 12'h123, 12'h9ab, 12'h456};
    rows[2] = '{8'h01, 12'h400, 12'h07f, 12'hc00, 12'h000};
    rows[3] = '{8'h07, 12'h555, 12'haaa, 12'h800, 12'h7ff};
    repeat (10) @(negedge clk_sys);
    chk({5'h0, link_byte_valid, entry_count}, 16'h0000);
    chk({13'h0, data_ready, level_reached, overflow}, 16'h0000);
    chk({link_byte, 7'h0, link_busy}, 16'h0000);
    reset_n = 1'b1;
    $display("test reset finished");
    for (int i = 0; i < 4; i++) begin
      cfg(rows[i].ctrl, 8'h80);
      put4(rows[i].x, rows[i].y, rows[i].z, rows[i].t);
      n = rows[i].ctrl[2] ? 4 : 3;
      chk(16'(entry_count), 16'(n));
      chk({15'h0, data_ready}, 16'h0001);
      v = '{rows[i].x, rows[i].y, rows[i].z, rows[i].t};
      for (int k = 0; k < n; k++) begin
        rd((k % 2) * 3, e);
        chk(e, ent(2'(k), v[k]));
      end
      cfg(8'h00, 8'h80);
    end
    rd(0, e);
    chk(e, 16'h0000);
    chk({15'h0, data_ready}, 16'h0000);
    $display("test rows finished");
    cfg(8'h05, 8'h80);
    fill(0, 128);
    chk(16'(entry_count), 16'h0200);
    chk({14'h0, level_reached, overflow}, 16'h0002);
    fill(128, 1);
    chk(16'(entry_count), 16'h0200);
    chk({15'h0, overflow}, 16'h0001);
    rd(3, e);
    chk(e, ent(2'b00, 12'h000));
    chk({15'h0, overflow}, 16'h0000);
    chk(16'(entry_count), 16'h01ff);
    fill(129, 1);
    chk({5'h0, overflow, entry_count}, 16'h0600);
    cfg(8'h00, 8'h80);
    chk({5'h0, overflow, entry_count}, 16'h0000);
    fill(0, 1);
    chk(16'(entry_count), 16'h0000);
    $display("test oldest finished");
    cfg(8'h02, 8'h06);
    fill(0, 1);
    chk({15'h0, level_reached}, 16'h0000);
    fill(1, 1);
    chk({15'h0, level_reached}, 16'h0001);
    rd(0, e);
    chk(e, ent(2'b00, 12'h000));
    chk({5'h0, level_reached, entry_count}, 16'h0005);
    cfg(8'h0a, 8'hff);
    fill(2, 170);
    chk({4'h0, level_reached, overflow, entry_count}, 16'h0e00);
    rd(3, e);
    chk(e, ent(2'b01, 12'h001));
    rd(0, e);
    chk({15'h0, level_reached}, 16'h0000);
    cfg(8'h00, 8'h80);
    $display("test stream finished");
    cfg(8'h03, 8'h06);
    fill(0, 4);
    chk({5'h0, overflow, entry_count}, 16'h0006);
    @(negedge clk_sys);
    activity_event = 1'b1;
    @(negedge clk_sys);
    activity_event = 1'b0;
    fill(4, 170);
    chk({5'h0, overflow, entry_count}, 16'h0200);
    rd(0, e);
    chk(e, ent(2'b00, 12'h002));
    fill(174, 1);
    chk(16'(entry_count), 16'h01ff);
    $display("test triggered finished");
    report_and_stop();
  end
endmodule
